/* File: rtl/csp_config_serial_port.sv */
`timescale 1ns/100ps
`include "csp_cfg.svh"
module csp_config_serial_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link pins
  input wire logic portSerialClock,
  input wire logic portSelectN,
  input wire logic portDataIn,
  output logic portDataOut,
  output logic portDataOe,
  output logic auxReadOut,
  output logic auxReadOe,
  // Device side
  output logic [511:0] cfgImage,
  output logic fourWireEnable,
  output logic readbackEnable,
  output logic powerOnResetReq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Pin synchroniser stages
  logic [2:0] sclkSync;
  logic [2:0] selSync;
  logic [2:0] dataSync;
  logic sclkF, selF, dataF;
  logic sclkPrev;
  logic next_sclkF, next_selF, next_dataF;
  logic sclkRise, sclkFall;
  // Sequencer state
  csp_pkg::csp_state_type state, next_state;
  logic [2:0] bitCount, next_bitCount;
  logic [7:0] shiftReg, next_shiftReg;
  logic [5:0] addr, next_addr;
  // Next values of registered outputs
  logic next_portDataOut, next_portDataOe;
  logic next_auxReadOut;
  logic next_powerOnResetReq;
  // Write strobe into the byte store
  logic wrEn;
  logic [5:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] hdrByte;
  // Applied bytes and staged high bytes
  logic [7:0] liveReg [0:63];
  logic [7:0] holdReg [0:63];
  logic [7:0] next_liveReg [0:63];
  logic [7:0] next_holdReg [0:63];
  logic [63:0] mbHighMask;
  logic auxTristate;

  assign mbHighMask = `CSP_MB_HIGH_MASK;

  // Power-on value of one register
  function automatic logic [7:0] resetValue(input logic [5:0] a);
    case (a)
      `CSP_ADDR_ACQLOW: resetValue = `CSP_RST_16;
      `CSP_ADDR_OUTCTLA: resetValue = `CSP_RST_18;
      `CSP_ADDR_OUTCTLB: resetValue = `CSP_RST_19;
      `CSP_ADDR_RATEDIV: resetValue = `CSP_RST_1A;
      default: resetValue = `CSP_RST_OTHER;
    endcase
  endfunction : resetValue

  // Value seen by a read at one address
  function automatic logic [7:0] readValue(input logic [5:0] a);
    if (a == `CSP_ADDR_REVISION) begin
      readValue = `CSP_REVISION_VALUE;
    end else begin
      readValue = liveReg[a];
    end
  endfunction : readValue

  // Register address carried by a header byte
  function automatic logic [5:0] headerAddr(input logic [7:0] h);
    headerAddr = h[`CSP_HDR_ADDR_MSB:`CSP_HDR_ADDR_LSB];
  endfunction : headerAddr

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Filtered level follows once flops two and three agree
  always_comb begin
    next_sclkF = (sclkSync[1] == sclkSync[2]) ? sclkSync[2] : sclkF;
    next_selF = (selSync[1] == selSync[2]) ? selSync[2] : selF;
    next_dataF = (dataSync[1] == dataSync[2]) ? dataSync[2] : dataF;
  end

  // Three-stage capture of link pins
  always_ff @(posedge clk) begin
    if (reset) begin
      // Idle pin levels: clock low, select high
      sclkSync <= 3'h0;
      selSync <= 3'h7;
      dataSync <= 3'h0;
      sclkF <= 1'b0;
      selF <= 1'b1;
      dataF <= 1'b0;
      sclkPrev <= 1'b0;
    end else begin
      sclkSync <= {sclkSync[1:0], portSerialClock};
      selSync <= {selSync[1:0], portSelectN};
      dataSync <= {dataSync[1:0], portDataIn};
      sclkF <= next_sclkF;
      selF <= next_selF;
      dataF <= next_dataF;
      sclkPrev <= sclkF;
    end
  end

  // Serial clock edges
  assign sclkRise = sclkF & ~sclkPrev;
  assign sclkFall = ~sclkF & sclkPrev;

  // ----------------------------------------
  // Port sequencer
  // ----------------------------------------
  // Incoming byte with the newest bit at the bottom
  assign hdrByte = {shiftReg[6:0], dataF};

  // Next state of the serial sequencer
  always_comb begin
    next_state = state;
    next_bitCount = bitCount;
    next_shiftReg = shiftReg;
    next_addr = addr;
    next_portDataOut = portDataOut;
    next_portDataOe = portDataOe;
    next_auxReadOut = auxReadOut;
    next_powerOnResetReq = 1'b0;
    wrEn = 1'b0;
    wrAddr = addr;
    wrData = hdrByte;
    if (selF) begin
      next_state = csp_pkg::CSP_IDLE;
      next_bitCount = 3'h0;
      next_portDataOe = 1'b0;
      next_portDataOut = 1'b0;
      next_auxReadOut = 1'b0;
    end else begin
      unique case (state)
        csp_pkg::CSP_IDLE: begin
          next_state = csp_pkg::CSP_HEADER;
          next_bitCount = 3'h0;
        end
        csp_pkg::CSP_HEADER: begin
          if (sclkRise) begin
            next_shiftReg = hdrByte;
            next_bitCount = bitCount + 3'h1;
            if (bitCount == `CSP_LAST_BIT) begin
              next_addr = headerAddr(hdrByte);
              if (hdrByte[`CSP_HDR_RW_BIT]) begin
                next_state = csp_pkg::CSP_READ;
                // Read byte loaded as the header completes
                next_shiftReg = readValue(headerAddr(hdrByte));
              end else begin
                // Data bytes follow the header
                next_state = csp_pkg::CSP_WRITE;
              end
            end
          end
        end
        csp_pkg::CSP_WRITE: begin
          if (sclkRise) begin
            // Shift the next data bit in
            next_shiftReg = hdrByte;
            next_bitCount = bitCount + 3'h1;
            if (bitCount == `CSP_LAST_BIT) begin
              wrEn = 1'b1;
              if (addr == `CSP_ADDR_REVISION && hdrByte == `CSP_SOFT_RESET_KEY) begin
                next_powerOnResetReq = 1'b1;
              end
              next_addr = addr + 6'h01;
            end
          end
        end
        csp_pkg::CSP_READ: begin
          if (sclkFall) begin
            next_portDataOut = shiftReg[7];
            next_portDataOe = readbackEnable;
            next_auxReadOut = fourWireEnable & shiftReg[7];
            // Move the next bit to the top
            next_shiftReg = {shiftReg[6:0], 1'b0};
            next_bitCount = bitCount + 3'h1;
            if (bitCount == `CSP_LAST_BIT) begin
              next_state = csp_pkg::CSP_HOLD;
            end
          end
        end
        csp_pkg::CSP_HOLD: begin
          // Last read bit stands until select rises
          next_state = csp_pkg::CSP_HOLD;
        end
        default: begin
          next_state = csp_pkg::CSP_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      // Idle, data line released
      state <= csp_pkg::CSP_IDLE;
      bitCount <= 3'h0;
      shiftReg <= 8'h00;
      addr <= 6'h00;
      portDataOut <= 1'b0;
      portDataOe <= 1'b0;
      auxReadOut <= 1'b0;
      powerOnResetReq <= 1'b0;
    end else begin
      state <= next_state;
      bitCount <= next_bitCount;
      shiftReg <= next_shiftReg;
      addr <= next_addr;
      portDataOut <= next_portDataOut;
      portDataOe <= next_portDataOe;
      auxReadOut <= next_auxReadOut;
      powerOnResetReq <= next_powerOnResetReq;
    end
  end

  // ----------------------------------------
  // Register space
  // ----------------------------------------
  // Next contents of the byte store
  always_comb begin
    next_liveReg = liveReg;
    next_holdReg = holdReg;
    if (powerOnResetReq) begin
      for (int i = 0; i < 64; i++) begin
        next_liveReg[i] = resetValue(6'(i));
        next_holdReg[i] = 8'h00;
      end
    end else if (wrEn && wrAddr != `CSP_ADDR_REVISION) begin
      if (mbHighMask[wrAddr]) begin
        next_holdReg[wrAddr] = wrData;
      end else begin
        next_liveReg[wrAddr] = wrData;
        if (wrAddr != 6'h00 && mbHighMask[wrAddr - 6'h01]) begin
          next_liveReg[wrAddr - 6'h01] = holdReg[wrAddr - 6'h01];
        end
      end
    end
  end

  // Byte store registers
  always_ff @(posedge clk) begin
    if (reset) begin
      // Power-on contents
      for (int i = 0; i < 64; i++) begin
        liveReg[i] <= resetValue(6'(i));
        holdReg[i] <= 8'h00;
      end
    end else begin
      liveReg <= next_liveReg;
      holdReg <= next_holdReg;
    end
  end

  // Flat image for the rest of the device
  generate
    for (genvar g = 0; g < 64; g++) begin : gImage
      assign cfgImage[g*8 +: 8] = liveReg[g];
    end
  endgenerate

  // ----------------------------------------
  // Control bit decode
  // ----------------------------------------
  // four-wire select
  assign fourWireEnable = liveReg[`CSP_ADDR_OUTCTLB][`CSP_FOURWIRE_BIT];
  assign readbackEnable = liveReg[`CSP_ADDR_READBACK][`CSP_READBACK_BIT];
  // Aux float control
  assign auxTristate = liveReg[`CSP_ADDR_AUXTRI][`CSP_AUXTRI_BIT];
  assign auxReadOe = ~auxTristate;

endmodule : csp_config_serial_port

/* File: rtl/csp_cfg.svh */
// Functional notes
// - Default link is three wires: serial clock, select low, shared data line.
// - Output control B bit 7 enables four-wire reads on auxiliary output.
// - Auxiliary output drives low after reset; 0x3B bit 3 floats it.
// - Header: direction bit on top, six address bits, lowest bit ignored.
// - Address and data bits travel most significant bit first.
// - With select low, header bits are sampled on serial clock rises.
// - Write: eight data bits on next eight rises; host holds select low.
// - Select rising before eight write bits aborts, register left unchanged.
// - Select held low for more bytes: address increments, short byte dropped.
// - Multibyte registers big-endian; value applied when low byte written.
// - Three-wire reads drive data only once readback enable 0x3A bit 3 set.
// - Read drives eight register bits on falling edges after the header.
// - Four-wire mode repeats read bits on auxiliary output, same timing.
// - Select rising after a read releases the data line to input.
// - Writing 0x99 to the revision register acts as a power-on reset.
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
// ----------------------------------------
// Register addresses and bits
// ----------------------------------------
`define CSP_ADDR_ACQLOW 6'h16
`define CSP_ADDR_OUTCTLA 6'h18
`define CSP_ADDR_OUTCTLB 6'h19
`define CSP_ADDR_RATEDIV 6'h1a
`define CSP_FOURWIRE_BIT 7
`define CSP_ADDR_READBACK 6'h3a
`define CSP_READBACK_BIT 3
`define CSP_ADDR_AUXTRI 6'h3b
`define CSP_AUXTRI_BIT 3
`define CSP_ADDR_REVISION 6'h3f
`define CSP_SOFT_RESET_KEY 8'h99
// Arbitrary revision code
`define CSP_REVISION_VALUE 8'h5a
// ----------------------------------------
// Header layout
// ----------------------------------------
`define CSP_HDR_RW_BIT 7
`define CSP_HDR_ADDR_MSB 6
`define CSP_HDR_ADDR_LSB 1
`define CSP_LAST_BIT 3'h7
// ----------------------------------------
// Multibyte high bytes and reset values
// ----------------------------------------
`define CSP_MB_HIGH_MASK 64'h0000_0000_0020_0000
`define CSP_RST_16 8'h04
`define CSP_RST_18 8'h12
`define CSP_RST_19 8'h07
`define CSP_RST_1A 8'h01
`define CSP_RST_OTHER 8'h00
`endif

/* File: rtl/csp_pkg.sv */
package csp_pkg;
  // Port sequencer states
  typedef enum logic [2:0] {
    CSP_IDLE = 3'b000,
    CSP_HEADER = 3'b001,
    CSP_WRITE = 3'b010,
    CSP_READ = 3'b011,
    CSP_HOLD = 3'b100
  } csp_state_type;
endpackage : csp_pkg

/* File: tb/csp_config_serial_port_properties.sv */
`timescale 1ns/100ps
module csp_config_serial_port_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial link pins
  input wire logic portSerialClock,
  input wire logic portSelectN,
  input wire logic portDataIn,
  input wire logic portDataOut,
  input wire logic portDataOe,
  input wire logic auxReadOut,
  input wire logic auxReadOe,
  // Device side
  input wire logic [511:0] cfgImage,
  input wire logic fourWireEnable,
  input wire logic readbackEnable,
  input wire logic powerOnResetReq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Select resynced high
  sequence s_idle;
    portSelectN [*8];
  endsequence
  property p_four;
    fourWireEnable == cfgImage[207];
  endproperty
  a_four: assert property (p_four) else $error("four-wire flag wrong");
  property p_rb;
    readbackEnable == cfgImage[467];
  endproperty
  a_rb: assert property (p_rb) else $error("readback flag wrong");
  property p_auxOe;
    auxReadOe == !cfgImage[475];
  endproperty
  a_auxOe: assert property (p_auxOe) else $error("aux enable wrong");
  property p_pdGate;
    portDataOe |-> readbackEnable;
  endproperty
  a_pdGate: assert property (p_pdGate) else $error("data drive without readback");
  property p_release;
    s_idle |-> !portDataOe;
  endproperty
  a_release: assert property (p_release) else $error("data line not released");
  property p_auxIdle;
    s_idle |-> !auxReadOut;
  endproperty
  a_auxIdle: assert property (p_auxIdle) else $error("aux not low when idle");
  property p_auxCopy;
    (portDataOe && fourWireEnable) |-> auxReadOut == portDataOut;
  endproperty
  a_auxCopy: assert property (p_auxCopy) else $error("aux copy differs");
  property p_auxOff;
    !fourWireEnable |-> !auxReadOut;
  endproperty
  a_auxOff: assert property (p_auxOff) else $error("aux driven in three-wire mode");
  property p_quiet;
    s_idle |=> $stable(cfgImage) || $past(powerOnResetReq) || $past(powerOnResetReq, 2);
  endproperty
  a_quiet: assert property (p_quiet) else $error("register changed while idle");
  property p_por;
    powerOnResetReq |-> ##3 (cfgImage[207:200] == 8'h07 && !readbackEnable);
  endproperty
  a_por: assert property (p_por) else $error("soft reset not applied");
  property p_porPulse;
    powerOnResetReq |=> !powerOnResetReq;
  endproperty
  a_porPulse: assert property (p_porPulse) else $error("reset request too long");
endmodule : csp_config_serial_port_properties
bind csp_config_serial_port csp_config_serial_port_properties u_props (.clk, .reset,
  .portSerialClock, .portSelectN, .portDataIn, .portDataOut, .portDataOe, .auxReadOut,
  .auxReadOe, .cfgImage, .fourWireEnable, .readbackEnable, .powerOnResetReq);

/* File: tb/csp_host_model.sv */
`timescale 1ns/100ps
module csp_host_model (
  // Edge alignment
  input wire logic clk,
  // Serial link pins
  output logic portSerialClock,
  output logic portSelectN,
  output logic portDataIn,
  input wire logic portDataOut,
  input wire logic portDataOe,
  input wire logic auxReadOut
);
  logic hostOe;
  logic hostBit;
  logic junk;
  assign portDataIn = portDataOe ? portDataOut : (hostOe ? hostBit : junk);
  // Idle pins, clock stands low
  initial begin
    portSerialClock = 1'b0;
    portSelectN = 1'b1;
    hostOe = 1'b0;
    hostBit = 1'b0;
    junk = 1'b0;
  end
  // Floating line toggles
  always @(posedge clk) junk <= ~junk;
  task automatic frame(input logic [23:0] bits, input int n, output logic [7:0] rdLine,
                       output logic [7:0] rdAux);
    @(posedge clk);
    #1 portSelectN = 1'b0;
    for (int i = 0; i < n; i++) begin
      hostOe = !(bits[23] && i >= 8);
      hostBit = bits[23-i];
      #40 portSerialClock = 1'b1;
      // Sample just before the falling edge, off the clock edge
      #38 rdLine = {rdLine[6:0], portDataIn};
      rdAux = {rdAux[6:0], auxReadOut};
      #2 portSerialClock = 1'b0;
    end
    #40 portSelectN = 1'b1;
    hostOe = 1'b0;
    #200;
  endtask : frame
endmodule : csp_host_model

/* File: tb/csp_config_serial_port_tb.sv */
`timescale 1ns/100ps
`include "csp_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module csp_config_serial_port_tb;
  logic clk, reset, portSerialClock, portSelectN, portDataIn, portDataOut, portDataOe;
  logic auxReadOut, auxReadOe, fourWireEnable, readbackEnable, powerOnResetReq;
  logic [511:0] cfgImage;
  logic [15:0] expQ[$];
  logic [15:0] gotQ[$];
  logic [15:0] mg, me;
  logic [7:0] rl, ra, v, w;
  logic oeSeen;
  int failures = 0;
  int cmp_count = 0;
  csp_config_serial_port u_dut (.clk, .reset, .portSerialClock, .portSelectN, .portDataIn,
    .portDataOut, .portDataOe, .auxReadOut, .auxReadOe, .cfgImage, .fourWireEnable,
    .readbackEnable, .powerOnResetReq);
  csp_host_model u_host (.clk, .portSerialClock, .portSelectN, .portDataIn, .portDataOut,
    .portDataOe, .auxReadOut);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task note(input logic [15:0] got, input logic [15:0] exp);
    gotQ.push_back(got);
    expQ.push_back(exp);
  endtask : note
  task wr(input logic [5:0] a, input logic [15:0] d, input int n);
    u_host.frame({1'b0, a, 1'($urandom), d}, n, rl, ra);
  endtask : wr
  task rd(input logic [5:0] a);
    u_host.frame({1'b1, a, 1'($urandom), 16'h0000}, 16, rl, ra);
  endtask : rd
  // Compare oldest note
  always @(posedge clk) begin
    if (gotQ.size() > 0) begin
      mg = gotQ.pop_front();
      me = expQ.pop_front();
      `CHK(mg, me)
    end
  end
  // Note any data line drive
  always @(posedge clk) begin
    if (portDataOe) begin
      oeSeen <= 1'b1;
    end
  end
  // Watchdog
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    v = 8'($urandom(32'h50d6));
    w = 8'($urandom);
    note({14'h0000, auxReadOe, auxReadOut}, 16'h0002);
    note({cfgImage[207:200], cfgImage[215:208]}, 16'h0701);
    wr(6'h20, {v, 8'h00}, 16);
    note({8'h00, cfgImage[263:256]}, {8'h00, v});
    wr(6'h24, 16'hff00, 5);
    wr(6'h20, {~v, 8'h00}, 12);
    note({cfgImage[295:288], cfgImage[263:256]}, {8'h00, v});
    wr(6'h22, {w, 8'h5a}, 19);
    note({cfgImage[279:272], cfgImage[287:280]}, {w, 8'h00});
    wr(6'h3f, {8'h11, v}, 24);
    note({8'h00, cfgImage[7:0]}, {8'h00, v});
    wr(6'h15, 16'h2a00, 16);
    note({cfgImage[175:168], cfgImage[183:176]}, 16'h0004);
    wr(6'h16, 16'h3300, 16);
    note({cfgImage[175:168], cfgImage[183:176]}, 16'h2a33);
    wr(6'h3a, 16'h0800, 16);
    rd(6'h20);
    note({rl, ra}, {v, 8'h00});
    note({15'h0000, portDataOe}, 16'h0000);
    wr(6'h19, 16'h8700, 16);
    rd(6'h20);
    note({rl, ra}, {v, v});
    rd(6'h3f);
    note({rl, ra}, {2{`CSP_REVISION_VALUE}});
    wr(6'h3b, 16'h0800, 16);
    note({15'h0000, auxReadOe}, 16'h0000);
    wr(6'h3f, 16'h9900, 16);
    note({cfgImage[207:200], 7'h00, readbackEnable}, 16'h0700);
    wr(6'h19, 16'h8000, 16);
    oeSeen = 1'b0;
    rd(6'h3f);
    note({7'h00, oeSeen, ra}, {8'h00, `CSP_REVISION_VALUE});
    repeat (4) @(posedge clk);
    report_and_stop;
  end
endmodule : csp_config_serial_port_tb
